// ===== logic/scg_defs.vh
// Constants for the sleep clock gating control block.
// Assumes inclusion by bare name from logic/ and dv/ files.
`ifndef SCG_DEFS_VH
`define SCG_DEFS_VH

// Register byte offsets within the system control window
`define SCG_OFF_RUN_GATE 12'h104
`define SCG_OFF_SLEEP_GATE 12'h114
`define SCG_OFF_DEEP_GATE 12'h124
`define SCG_OFF_CLK_CFG 12'h060
`define SCG_OFF_IRQ_STAT 12'h300
`define SCG_OFF_IRQ_MASK 12'h304
`define SCG_OFF_PWR_STAT 12'h308
`define SCG_OFF_FAULT_ADDR 12'h30C

// System control base address of the register window
`define SCG_BASE_ADDR 32'h400FE000
`define SCG_WIN_MASK 32'hFFFFF000

// Address window base of each gated unit, 4 KB each; the map is our own,
// and the three comparators share one window
`define SCG_WIN_ASP0 32'h4000C000
`define SCG_WIN_ASP1 32'h4000D000
`define SCG_WIN_ASP2 32'h4000E000
`define SCG_WIN_SSP0 32'h40008000
`define SCG_WIN_QEN0 32'h4002C000
`define SCG_WIN_TWP0 32'h40020000
`define SCG_WIN_CNT0 32'h40030000
`define SCG_WIN_CNT1 32'h40031000
`define SCG_WIN_CNT2 32'h40032000
`define SCG_WIN_CMP 32'h4003C000

// Writable gating bits; reserved bits read as zero
`define SCG_GATE_MASK 32'h07071117
`define SCG_GATE_RESET 32'h00000000

// Field positions of the gating register
`define SCG_BIT_CMP2 26
`define SCG_BIT_CMP1 25
`define SCG_BIT_CMP0 24
`define SCG_BIT_CNT2 18
`define SCG_BIT_CNT1 17
`define SCG_BIT_CNT0 16
`define SCG_BIT_TWP0 12
`define SCG_BIT_QEN0 8
`define SCG_BIT_SSP0 4
`define SCG_BIT_ASP2 2
`define SCG_BIT_ASP1 1
`define SCG_BIT_ASP0 0

// Automatic gating select bit in the clock configuration register
`define SCG_BIT_AUTO_GATE 27
`define SCG_CLK_CFG_RESET 32'h00000000

// Interrupt status bits
`define SCG_IRQ_FAULT 0
`define SCG_IRQ_MODE 1
`define SCG_IRQ_W 2

// Power states
`define SCG_PWR_RUN 2'h0
`define SCG_PWR_SLEEP 2'h1
`define SCG_PWR_DEEP 2'h2

`endif

// ===== logic/scg_pin_sync.v
// Three-stage synchroniser for a bundle of pin inputs.
// Assumes inputs arrive from outside the CLK_I domain.
`default_nettype none

module scg_pin_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Asynchronous inputs and their settled copy
  input wire [W-1:0] async_i,
  output reg [W-1:0] level_o
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // Stage one feeds only stage two, so no logic sees a metastable value
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          level_o[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          level_o[g] <= s3_q[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== logic/scg_gate_cell.v
// Glitch-free clock enable for one peripheral.
// Assumes the consumer uses the enable with a latch-based gate cell.
`default_nettype none

module scg_gate_cell (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Selected gating bit and the registered enable
  input wire want_i,
  output reg en_o
);

  // Registered so the enable only moves on a clock edge
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_o <= 1'b0;
    end else begin
      en_o <= want_i;
    end
  end

endmodule

`default_nettype wire

// ===== logic/scg_top.v
// Sleep clock gating control: APB register file, per-peripheral
// clock enables selected by power state, and bus-fault screening.
// Assumes an APB master on CLK_I and power state pins from the
// power controller, which are asynchronous to CLK_I.
// Each enable feeds a latch-based clock gate cell outside this block.
//
// How it works
// - In Sleep, set bit clocks its peripheral; clear bit leaves it off.
// - Access to a peripheral whose clock is off gets a bus fault.
// - Sleep gating register resets to zero, all peripherals unclocked.
// - Run, sleep and deep-sleep registers share layout, picked by state.
// - Sleep and deep registers apply only when auto gating bit is set.
// - Bits 26..24 gate comparators 2..0, read/write, reset zero.
// - Bits 18..16 gate timers 2..0, read/write, reset zero.
// - Bit 12 gates two-wire port 0, bit 8 quadrature encoder 0.
// - Bit 4 gates sync serial port 0, bit 2 async serial port 2.
// - Bits 1 and 0 gate async serial ports 1 and 0.
// - Reserved bits are read-only and read as zero.
// - Sleep gating register sits at offset 0x114, 32 bits wide.
//
// Our own choice: the APB slave port.
`default_nettype none
`include "scg_defs.vh"

module scg_top #(
  parameter NPERIPH = 12
) (
  // Clock and reset
  input wire CLK_I,
  input wire RESET_I,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // Power state from the power controller: bit0 sleep, bit1 deep
  input wire [1:0] PWR_STATE_I,
  // Peripheral access screening: address of a system bus request
  input wire SYS_REQ_I,
  input wire [31:0] SYS_ADDR_I,
  output reg SYS_FAULT_O,
  // Clock enables, one per gated peripheral in register bit order
  output wire [NPERIPH-1:0] PERIPH_CLK_EN_O,
  // Interrupt
  output reg IRQ_O
);

  // Gating bit position of each peripheral, enable index order
  function integer bit_of;
    input integer idx;
    begin
      case (idx)
        0: bit_of = `SCG_BIT_ASP0;
        1: bit_of = `SCG_BIT_ASP1;
        2: bit_of = `SCG_BIT_ASP2;
        3: bit_of = `SCG_BIT_SSP0;
        4: bit_of = `SCG_BIT_QEN0;
        5: bit_of = `SCG_BIT_TWP0;
        6: bit_of = `SCG_BIT_CNT0;
        7: bit_of = `SCG_BIT_CNT1;
        8: bit_of = `SCG_BIT_CNT2;
        9: bit_of = `SCG_BIT_CMP0;
        10: bit_of = `SCG_BIT_CMP1;
        default: bit_of = `SCG_BIT_CMP2;
      endcase
    end
  endfunction

  // Peripheral address window base, 4 KB per unit, enable index order
  function [31:0] base_of;
    input integer idx;
    begin
      case (idx)
        0: base_of = `SCG_WIN_ASP0;
        1: base_of = `SCG_WIN_ASP1;
        2: base_of = `SCG_WIN_ASP2;
        3: base_of = `SCG_WIN_SSP0;
        4: base_of = `SCG_WIN_QEN0;
        5: base_of = `SCG_WIN_TWP0;
        6: base_of = `SCG_WIN_CNT0;
        7: base_of = `SCG_WIN_CNT1;
        8: base_of = `SCG_WIN_CNT2;
        9: base_of = `SCG_WIN_CMP;
        10: base_of = `SCG_WIN_CMP;
        default: base_of = `SCG_WIN_CMP;
      endcase
    end
  endfunction

  // Power state encodings
  localparam [1:0] ST_RUN = `SCG_PWR_RUN;
  localparam [1:0] ST_SLEEP = `SCG_PWR_SLEEP;
  localparam [1:0] ST_DEEP = `SCG_PWR_DEEP;

  // Software-visible registers
  reg [31:0] run_gate_q;
  reg [31:0] sleep_gate_q;
  reg [31:0] deep_gate_q;
  reg [31:0] clk_cfg_q;
  reg [`SCG_IRQ_W-1:0] irq_stat_q;
  reg [`SCG_IRQ_W-1:0] irq_mask_q;
  reg [31:0] fault_addr_q;

  // Power state tracking
  reg [1:0] pwr_q;
  reg [1:0] pwr_prev_q;
  wire [1:0] pwr_sync;
  wire mode_change;

  // Gating selection and access screening
  reg [31:0] gate_sel;
  wire auto_gate;
  wire [NPERIPH-1:0] unit_hit;
  wire fault_hit;

  // Register bus decode
  reg [31:0] rdata_d;
  reg rd_hit;
  wire apb_setup;
  wire apb_access;
  wire apb_wr;
  wire apb_rd;
  wire wr_run;
  wire wr_sleep;
  wire wr_deep;
  wire wr_cfg;
  wire wr_mask;
  wire rd_stat;

  // Power state pins cross into CLK_I before anything reads them
  scg_pin_sync #(
    .W(2)
  ) u_pwr_sync (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .async_i(PWR_STATE_I),
    .level_o(pwr_sync)
  );

  // Deep-sleep wins if both state pins are high.
  // The pins are only read through the synchroniser, so a slow edge
  // on them costs a few cycles of latency but never a split decision.
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pwr_q <= ST_RUN;
      pwr_prev_q <= ST_RUN;
    end else begin
      pwr_prev_q <= pwr_q;
      if (pwr_sync[1]) begin
        pwr_q <= ST_DEEP;
      end else if (pwr_sync[0]) begin
        pwr_q <= ST_SLEEP;
      end else begin
        pwr_q <= ST_RUN;
      end
    end
  end

  assign mode_change = (pwr_q != pwr_prev_q);
  assign auto_gate = clk_cfg_q[`SCG_BIT_AUTO_GATE];

  // APB: zero-wait slave, write takes effect in the access cycle
  assign apb_setup = PSEL_I & ~PENABLE_I;
  assign apb_access = PSEL_I & PENABLE_I;
  assign apb_wr = apb_access & PWRITE_I;
  assign apb_rd = apb_access & ~PWRITE_I;

  // One write strobe per writable register; unmapped writes are dropped
  assign wr_run = apb_wr & (PADDR_I == `SCG_OFF_RUN_GATE);
  assign wr_sleep = apb_wr & (PADDR_I == `SCG_OFF_SLEEP_GATE);
  assign wr_deep = apb_wr & (PADDR_I == `SCG_OFF_DEEP_GATE);
  assign wr_cfg = apb_wr & (PADDR_I == `SCG_OFF_CLK_CFG);
  assign wr_mask = apb_wr & (PADDR_I == `SCG_OFF_IRQ_MASK);

  // Status clears only in the access cycle of a read of its own offset
  assign rd_stat = apb_rd & PREADY_O & (PADDR_I == `SCG_OFF_IRQ_STAT);

  // Pick the gating register that rules in the present power state.
  // Without auto gating the run register stays in charge while asleep.
  // Deep-sleep takes the same route through its own register.
  always @* begin
    case (pwr_q)
      ST_RUN: gate_sel = run_gate_q;
      ST_SLEEP: gate_sel = auto_gate ? sleep_gate_q : run_gate_q;
      ST_DEEP: gate_sel = auto_gate ? deep_gate_q : run_gate_q;
      default: gate_sel = run_gate_q;
    endcase
  end

  // One registered enable per peripheral, mapped to its gating bit.
  // The enable moves one cycle after the selection, so a write and a
  // power state change landing together still give one clean step.
  genvar g;
  generate
    for (g = 0; g < NPERIPH; g = g + 1) begin : g_gate
      scg_gate_cell u_cell (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .want_i(gate_sel[bit_of(g)]),
        .en_o(PERIPH_CLK_EN_O[g])
      );
    end
  endgenerate

  // Screen system bus requests against the units now unclocked; the
  // three comparators share one window, so any of them off faults it
  generate
    for (g = 0; g < NPERIPH; g = g + 1) begin : g_screen
      assign unit_hit[g] = SYS_REQ_I
        && ((SYS_ADDR_I & `SCG_WIN_MASK) == base_of(g))
        && !gate_sel[bit_of(g)];
    end
  endgenerate
  assign fault_hit = |unit_hit;

  // Fault pulse registered so every output comes from a flip-flop
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SYS_FAULT_O <= 1'b0;
    end else begin
      SYS_FAULT_O <= fault_hit;
    end
  end

  // Last faulting address kept for software; a later fault overwrites it
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fault_addr_q <= 32'h00000000;
    end else if (fault_hit) begin
      fault_addr_q <= SYS_ADDR_I;
    end
  end

  // Run gating register; in charge whenever auto gating is off
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      run_gate_q <= `SCG_GATE_RESET;
    end else if (wr_run) begin
      run_gate_q <= PWDATA_I & `SCG_GATE_MASK;
    end
  end

  // Sleep gating register; power state changes never touch it, only
  // software writes, so it survives every trip into and out of Sleep
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sleep_gate_q <= `SCG_GATE_RESET;
    end else if (wr_sleep) begin
      sleep_gate_q <= PWDATA_I & `SCG_GATE_MASK;
    end
  end

  // Deep-sleep gating register, same layout as the other two
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      deep_gate_q <= `SCG_GATE_RESET;
    end else if (wr_deep) begin
      deep_gate_q <= PWDATA_I & `SCG_GATE_MASK;
    end
  end

  // Clock configuration; only the auto gating bit is used here
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      clk_cfg_q <= `SCG_CLK_CFG_RESET;
    end else if (wr_cfg) begin
      clk_cfg_q <= PWDATA_I;
    end
  end

  // Interrupt mask, same layout as the status register
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_mask_q <= {`SCG_IRQ_W{1'b0}};
    end else if (wr_mask) begin
      irq_mask_q <= PWDATA_I[`SCG_IRQ_W-1:0];
    end
  end

  // Read mux; unmapped offsets answer zero with an error.
  // Reads have no side effect here; the status clear is decoded apart.
  always @* begin
    rdata_d = 32'h00000000;
    rd_hit = 1'b1;
    case (PADDR_I)
      `SCG_OFF_RUN_GATE: rdata_d = run_gate_q;
      `SCG_OFF_SLEEP_GATE: rdata_d = sleep_gate_q;
      `SCG_OFF_DEEP_GATE: rdata_d = deep_gate_q;
      `SCG_OFF_CLK_CFG: rdata_d = clk_cfg_q;
      `SCG_OFF_IRQ_STAT: rdata_d = {{(32-`SCG_IRQ_W){1'b0}}, irq_stat_q};
      `SCG_OFF_IRQ_MASK: rdata_d = {{(32-`SCG_IRQ_W){1'b0}}, irq_mask_q};
      `SCG_OFF_PWR_STAT: rdata_d = {30'h0, pwr_q};
      `SCG_OFF_FAULT_ADDR: rdata_d = fault_addr_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer registered in the setup cycle so PREADY rises in access.
  // Read data thus stands through the whole access phase; the price is
  // that every transfer takes its full two cycles.
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PRDATA_O <= 32'h00000000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= apb_setup;
      PSLVERR_O <= apb_setup & ~rd_hit;
      if (apb_setup & ~PWRITE_I) begin
        PRDATA_O <= rdata_d;
      end
    end
  end

  // Sticky events; a set in the clearing read's cycle wins,
  // but an event set in the read's setup cycle misses the read data and is then cleared
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_stat_q <= {`SCG_IRQ_W{1'b0}};
    end else begin
      if (rd_stat) begin
        irq_stat_q <= {`SCG_IRQ_W{1'b0}};
      end
      if (fault_hit) begin
        irq_stat_q[`SCG_IRQ_FAULT] <= 1'b1;
      end
      if (mode_change) begin
        irq_stat_q[`SCG_IRQ_MODE] <= 1'b1;
      end
    end
  end

  // Level interrupt while any unmasked status bit is set.
  // It trails the status by one cycle, harmless for a level request.
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

`default_nettype wire

// ===== dv/scg_properties.sv
// Checker for the sleep clock gating block: APB timing, faults, enables.
// Assumes it is bound to scg_top and sees only that module's ports.
`default_nettype none
`include "scg_defs.vh"

module scg_properties (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // APB
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Power state, screening, enables
  input wire logic [1:0] PWR_STATE_I,
  input wire logic SYS_REQ_I,
  input wire logic SYS_FAULT_O,
  input wire logic [11:0] PERIPH_CLK_EN_O
);
  logic [3:0] quiet_q;
  logic [1:0] pwr_q;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  // Cycles since a pin change or a write; enables may only move soon after
  always @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      quiet_q <= 4'h0;
      pwr_q <= 2'h0;
    end else begin
      pwr_q <= PWR_STATE_I;
      if (pwr_q != PWR_STATE_I || (PREADY_O && PWRITE_I))
        quiet_q <= 4'h0;
      else if (quiet_q != 4'hF)
        quiet_q <= quiet_q + 4'h1;
    end
  end

  chk_ready_zero_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("ready missing in access cycle");
  chk_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("ready outside access cycle");
  chk_err_with_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  chk_sleep_mapped: assert property (PREADY_O &&
    PADDR_I == `SCG_OFF_SLEEP_GATE |-> !PSLVERR_O)
    else $error("sleep gate offset refused");
  chk_reserved_zero: assert property (PREADY_O && !PWRITE_I &&
    PADDR_I == `SCG_OFF_SLEEP_GATE |-> (PRDATA_O & 32'hF8F8EEE8) == 32'h0)
    else $error("reserved bit reads one");
  chk_fault_cause: assert property (SYS_FAULT_O |-> $past(SYS_REQ_I))
    else $error("fault without request");
  chk_reset_unclocked: assert property ($fell(RESET_I) |->
    PERIPH_CLK_EN_O == 12'h000)
    else $error("unit clocked after reset");
  chk_rdata_hold: assert property ($changed(PRDATA_O) |->
    $past(PSEL_I && !PENABLE_I && !PWRITE_I))
    else $error("read data moved without read");
  chk_enable_settle: assert property ($changed(PERIPH_CLK_EN_O) |->
    quiet_q < 4'hA)
    else $error("enable moved without cause");

  // Main scenarios
  cover property (PREADY_O && PSLVERR_O);
  cover property (PERIPH_CLK_EN_O == 12'hFFF);
  cover property (SYS_REQ_I && !SYS_FAULT_O);
  cover property (SYS_FAULT_O);
endmodule

bind scg_top scg_properties chk (.CLK_I, .RESET_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .PWR_STATE_I,
  .SYS_REQ_I, .SYS_FAULT_O, .PERIPH_CLK_EN_O);
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the sleep clock gating block.
// Assumes scg_top with its default of twelve gated units.
`default_nettype none
`include "scg_defs.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic sreq = 1'b0, prdy, perr, sflt, irq, er;
  logic [11:0] pa = 12'h000, en;
  logic [31:0] pwd = 32'h0, sadr = 32'h0, prd, rd;
  logic [1:0] pst = 2'h0;
  int fails = 0, compares = 0, cyc = 0;
  // Gating bit positions in enable order
  int pos [12] = '{0, 1, 2, 4, 8, 12, 16, 17, 18, 24, 25, 26};

  scg_top DUT (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .PWR_STATE_I(pst), .SYS_REQ_I(sreq),
    .SYS_ADDR_I(sadr), .SYS_FAULT_O(sflt), .PERIPH_CLK_EN_O(en), .IRQ_O(irq));

  always #5 clk = ~clk;

  // Hang guard; the tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; ready, data and error are taken at the rising
  // edge that ends the access phase, and only then is the request dropped
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  function automatic logic [31:0] pick(input logic [31:0] v);
    pick = 32'h0;
    for (int i = 0; i < 12; i++) pick[i] = v[pos[i]];
  endfunction

  // Pins pass a slow synchroniser, so allow it time to settle
  task automatic state(input logic [1:0] s);
    @(posedge clk);
    pst <= s;
    repeat (10) @(posedge clk);
  endtask

  task automatic t_reset;
    apb(1'b0, `SCG_OFF_SLEEP_GATE, 32'h0);
    check(rd, 32'h00000000);
    check({20'h0, en}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_fields;
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, `SCG_OFF_SLEEP_GATE, 32'h1 << pos[i]);
      apb(1'b0, `SCG_OFF_SLEEP_GATE, 32'h0);
      check(rd, 32'h1 << pos[i]);
    end
    apb(1'b1, `SCG_OFF_SLEEP_GATE, 32'hFFFFFFFF);
    apb(1'b1, 12'h200, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b0, `SCG_OFF_SLEEP_GATE, 32'h0);
    check(rd, 32'h07071117);
    $display("test fields done");
  endtask

  task automatic t_modes;
    apb(1'b1, `SCG_OFF_RUN_GATE, 32'h00000011);
    apb(1'b1, `SCG_OFF_SLEEP_GATE, 32'h07000005);
    apb(1'b1, `SCG_OFF_DEEP_GATE, 32'h00170100);
    state(2'h1);
    check({20'h0, en}, pick(32'h11));
    apb(1'b1, `SCG_OFF_CLK_CFG, 32'h08000000);
    repeat (4) @(posedge clk);
    check({20'h0, en}, pick(32'h07000005));
    state(2'h3);
    check({20'h0, en}, pick(32'h00170100));
    apb(1'b0, `SCG_OFF_PWR_STAT, 32'h0);
    check(rd, {30'h0, `SCG_PWR_DEEP});
    state(2'h0);
    check({20'h0, en}, pick(32'h11));
    apb(1'b0, `SCG_OFF_SLEEP_GATE, 32'h0);
    check(rd, 32'h07000005);
    $display("test modes done");
  endtask

  task automatic t_irq;
    apb(1'b1, `SCG_OFF_IRQ_MASK, 32'h0);
    apb(1'b0, `SCG_OFF_IRQ_STAT, 32'h0);
    state(2'h1);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, `SCG_OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, `SCG_OFF_IRQ_STAT, 32'h0);
    check(rd & 32'h2, 32'h2);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    $display("test interrupt done");
  endtask

  // With every unit clocked no request may fault; with one off, it must
  task automatic t_sys;
    apb(1'b1, `SCG_OFF_SLEEP_GATE, 32'hFFFFFFFF);
    repeat (4) @(posedge clk);
    check({20'h0, en}, 32'hFFF);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      sreq <= 1'b1;
      sadr <= 32'h40000000 + (32'(i) << 12);
      @(negedge clk);
      check({31'h0, sflt}, 32'h0);
    end
    @(posedge clk);
    sreq <= 1'b0;
    apb(1'b1, `SCG_OFF_SLEEP_GATE, 32'hFFFFFFFE);
    @(posedge clk);
    sreq <= 1'b1;
    sadr <= `SCG_WIN_ASP0 + 32'h10;
    @(posedge clk);
    sreq <= 1'b0;
    @(negedge clk);
    check({31'h0, sflt}, 32'h1);
    apb(1'b0, `SCG_OFF_FAULT_ADDR, 32'h0);
    check(rd, `SCG_WIN_ASP0 + 32'h10);
    apb(1'b0, `SCG_OFF_IRQ_STAT, 32'h0);
    check(rd & 32'h1, 32'h1);
    $display("test screening done");
  endtask

  task automatic end_sim;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_modes();
    t_irq();
    t_sys();
    end_sim();
  end
endmodule
`default_nettype wire
